// >>> pkg/sar_adc_pkg.sv
// constants, register map and types of the successive-approximation converter control
package sar_adc_pkg;
	localparam logic [15:0] ADDR_RESULT_WORD = 16'hff06;
	localparam logic [15:0] ADDR_RESULT_HIGH = 16'hff07;
	localparam logic [15:0] ADDR_MODE        = 16'hff08;
	localparam logic [15:0] ADDR_CHANNEL     = 16'hff8e;

	localparam logic [7:0] MODE_RESET   = 8'h00;
	localparam logic [2:0] CHAN_RESET   = 3'h0;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [2:0] CHAN_LAST    = 3'h5;

	localparam int MODE_ENABLE_BIT = 7;
	localparam int MODE_TIME_MSB   = 6;
	localparam int MODE_TIME_LSB   = 3;
	localparam int MODE_RANGE_MSB  = 2;
	localparam int MODE_RANGE_LSB  = 1;
	localparam int MODE_COMP_BIT   = 0;
	localparam int CHAN_WIDTH      = 3;

	localparam logic [5:0] RESULT_PAD_ZERO = 6'h00;
	localparam logic [7:0] HIGH_BYTE_ZERO  = 8'h00;
	localparam logic [4:0] BYTE_PAD_ZERO   = 5'h00;

	localparam logic [1:0] RANGE_NORMAL = 2'h0;
	localparam logic [1:0] RANGE_LOW    = 2'h1;
	localparam logic [3:0] TIME_CODE_0  = 4'h0;
	localparam logic [3:0] TIME_CODE_1  = 4'h1;
	localparam logic [3:0] TIME_CODE_2  = 4'h2;
	localparam logic [3:0] TIME_CODE_3  = 4'h3;
	localparam logic [3:0] TIME_CODE_4  = 4'h4;
	localparam logic [3:0] TIME_CODE_5  = 4'h5;

	localparam logic [4:0] DIV_16   = 5'h10;
	localparam logic [4:0] DIV_12   = 5'h0c;
	localparam logic [4:0] DIV_8    = 5'h08;
	localparam logic [4:0] DIV_6    = 5'h06;
	localparam logic [4:0] DIV_4    = 5'h04;
	localparam logic [4:0] DIV_3    = 5'h03;
	localparam logic [4:0] DIV_2    = 5'h02;
	localparam logic [4:0] DIV_STEP = 5'h01;

	localparam logic [5:0] PERIODS_NORMAL = 6'h16;
	localparam logic [5:0] PERIODS_LOW    = 6'h28;
	localparam logic [5:0] SAR_STEPS      = 6'h0a;
	localparam logic [5:0] PERIOD_STEP    = 6'h01;

	localparam logic [9:0] SAR_MSB_CODE = 10'h200;
	localparam logic [3:0] SAR_MSB_POS  = 4'h9;
	localparam logic [3:0] SAR_LSB_POS  = 4'h0;
	localparam logic [3:0] SAR_POS_STEP = 4'h1;

	typedef enum logic [1:0] {CONV_IDLE, CONV_SAMPLE, CONV_APPROX} conv_state_e;
endpackage

// >>> pkg/conv_core_if.sv
// carrier between the converter control, its clock divider and its bit engine
`timescale 1ns/100ps
`default_nettype none
interface conv_core_if;
	logic [4:0] divRatio;
	logic       divRun;
	logic       tick;
	logic       sarStart;
	logic       sarStep;
	logic       compHigh;
	logic [9:0] trialCode;
	logic       sarDone;
	logic [9:0] sarCode;

	modport ctrl (output divRatio, divRun, sarStart, sarStep, compHigh,
		input tick, trialCode, sarDone, sarCode);
	modport divider (input divRatio, divRun, output tick);
	modport sar (input sarStart, sarStep, compHigh, output trialCode, sarDone, sarCode);
endinterface
`default_nettype wire

// >>> rtl/conv_clock_divider.sv
// conversion-clock divider giving a one-cycle enable per conversion-clock period
`timescale 1ns/100ps
`default_nettype none
module conv_clock_divider (
	input wire logic    ref_clk,
	input wire logic    reset_n,
	conv_core_if.divider core
);
	import sar_adc_pkg::*;

	typedef struct packed {
		logic [4:0] count;
		logic       tick;
	} div_s;

	div_s cur_ff;
	div_s nxt_ff;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.tick = 1'b0;
		// held at zero while stopped so a conversion started from stop begins on a full period
		if (!core.divRun) begin
			nxt_ff.count = 5'h00;
		end else if (cur_ff.count == core.divRatio - DIV_STEP) begin
			nxt_ff.count = 5'h00;
			nxt_ff.tick = 1'b1;
		end else begin
			nxt_ff.count = cur_ff.count + DIV_STEP;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign core.tick = cur_ff.tick;
endmodule
`default_nettype wire

// >>> rtl/sar_bit_engine.sv
// successive-approximation register: one bit decided per step, msb first
`timescale 1ns/100ps
`default_nettype none
module sar_bit_engine (
	input wire logic ref_clk,
	input wire logic reset_n,
	conv_core_if.sar core
);
	import sar_adc_pkg::*;

	typedef struct packed {
		logic [9:0] code;
		logic [3:0] pos;
		logic       done;
		logic [9:0] result;
	} sar_s;

	sar_s cur_ff;
	sar_s nxt_ff;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.done = 1'b0;
		if (core.sarStart) begin
			nxt_ff.code = SAR_MSB_CODE;
			nxt_ff.pos = SAR_MSB_POS;
		end else if (core.sarStep) begin
			// comparator high means the held input is at or above the trial level
			nxt_ff.code[cur_ff.pos] = core.compHigh;
			if (cur_ff.pos == SAR_LSB_POS) begin
				nxt_ff.done = 1'b1;
				nxt_ff.result = nxt_ff.code;
			end else begin
				nxt_ff.pos = cur_ff.pos - SAR_POS_STEP;
				nxt_ff.code[nxt_ff.pos] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign core.trialCode = cur_ff.code;
	assign core.sarDone = cur_ff.done;
	assign core.sarCode = cur_ff.result;
endmodule
`default_nettype wire

// >>> rtl/sar_adc_mode_and_result.sv
// converter mode and channel registers, conversion sequencer and result registers
// Function
// - mode register takes bit or byte writes and clears to zero on reset
// - enable bit at 0 halts conversion, at 1 converts repeatedly
// - comparator powered while either enable bit or comparator bit is set
// - bit pair decodes to stopped, waiting, converting cold, converting warm
// - writing the mode register inserts one bus wait cycle
// - normal range: time code selects divider 16,12,8,6,4,3,2; others prohibited
// - low range: time code selects divider 12,8,6,4,3,2; others prohibited
// - result word is 16 bits with the 10-bit result left-justified
// - low six bits of the result word read zero
// - each conversion end copies the approximation register into the result
// - upper eight result bits at high byte, low two atop the low byte
// - result word read as 16 bits and cleared to zero on reset
// - each conversion end raises a conversion-done interrupt request
// - selected input sampled at start and held through the conversion
// - separate read-only high byte register holds upper eight result bits
// - three-bit channel field selects inputs 0 to 5; 6 and 7 prohibited
`timescale 1ns/100ps
`default_nettype none
module sar_adc_mode_and_result (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWrData,
	input  wire logic        memWrEn,
	input  wire logic        memBitWrEn,
	input  wire logic [2:0]  memBitIdx,
	input  wire logic        memRdEn,
	input  wire logic        compHigh,
	output logic      [15:0] memRdData,
	output logic             memWait,
	output logic      [9:0]  trialCode,
	output logic             trackInput,
	output logic             compPowerOn,
	output logic      [2:0]  channelSel,
	output logic             conversion_done_irq
);
	import sar_adc_pkg::*;

	typedef struct packed {
		logic [7:0]  mode;
		logic [2:0]  chan;
		logic [9:0]  result;
		logic [15:0] rdData;
		logic        waitCyc;
		logic        irq;
		conv_state_e st;
		logic [5:0]  periods;
		logic        track;
		logic        compPower;
	} ctrl_s;

	ctrl_s cur_ff;
	ctrl_s nxt_ff;

	conv_core_if core ();

	conv_clock_divider u_divider (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.core    (core.divider)
	);

	sar_bit_engine u_sar (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.core    (core.sar)
	);

	logic       modeAcc;
	logic       chanAcc;
	logic [7:0] modeWr;
	logic [7:0] chanWr;
	logic [3:0] timeCode;
	logic [1:0] rangeCode;
	logic       timingOk;
	logic       convEnable;
	logic [4:0] ratio;
	logic [5:0] periodsTotal;
	logic [5:0] sampleLast;

	// time and range decode, taken from the value being written this cycle
	always_comb begin
		timeCode = nxt_ff.mode[MODE_TIME_MSB:MODE_TIME_LSB];
		rangeCode = nxt_ff.mode[MODE_RANGE_MSB:MODE_RANGE_LSB];
		timingOk = 1'b1;
		ratio = DIV_2;
		periodsTotal = PERIODS_NORMAL;
		if (rangeCode == RANGE_NORMAL) begin
			periodsTotal = PERIODS_NORMAL;
			if (timeCode[3]) begin
				ratio = DIV_16;
			end else if (timeCode == TIME_CODE_0) begin
				ratio = DIV_12;
			end else if (timeCode == TIME_CODE_1) begin
				ratio = DIV_8;
			end else if (timeCode == TIME_CODE_2) begin
				ratio = DIV_6;
			end else if (timeCode == TIME_CODE_3) begin
				ratio = DIV_4;
			end else if (timeCode == TIME_CODE_4) begin
				ratio = DIV_3;
			end else if (timeCode == TIME_CODE_5) begin
				ratio = DIV_2;
			end else begin
				timingOk = 1'b0;
			end
		end else if (rangeCode == RANGE_LOW) begin
			periodsTotal = PERIODS_LOW;
			if (timeCode == TIME_CODE_0) begin
				ratio = DIV_12;
			end else if (timeCode == TIME_CODE_1) begin
				ratio = DIV_8;
			end else if (timeCode == TIME_CODE_2) begin
				ratio = DIV_6;
			end else if (timeCode == TIME_CODE_3) begin
				ratio = DIV_4;
			end else if (timeCode == TIME_CODE_4) begin
				ratio = DIV_3;
			end else if (timeCode == TIME_CODE_5) begin
				ratio = DIV_2;
			end else begin
				timingOk = 1'b0;
			end
		end else begin
			timingOk = 1'b0;
		end
		// prohibited settings simply never start a conversion
		convEnable = nxt_ff.mode[MODE_ENABLE_BIT] && timingOk
			&& (nxt_ff.chan <= CHAN_LAST);
		sampleLast = periodsTotal - SAR_STEPS - PERIOD_STEP;
	end

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.irq = 1'b0;
		nxt_ff.waitCyc = 1'b0;
		modeAcc = (memWrEn || memBitWrEn) && (memAddr == ADDR_MODE);
		chanAcc = (memWrEn || memBitWrEn) && (memAddr == ADDR_CHANNEL);
		modeWr = cur_ff.mode;
		modeWr[memBitIdx] = memWrData[0];
		chanWr = {BYTE_PAD_ZERO, cur_ff.chan};
		chanWr[memBitIdx] = memWrData[0];
		if (memWrEn) begin
			modeWr = memWrData;
			chanWr = memWrData;
		end
		if (modeAcc) begin
			nxt_ff.mode = modeWr;
			nxt_ff.waitCyc = 1'b1;
		end else if (chanAcc) begin
			nxt_ff.chan = chanWr[CHAN_WIDTH-1:0];
			nxt_ff.waitCyc = 1'b1;
		end

		if (memRdEn) begin
			if (memAddr == ADDR_RESULT_WORD) begin
				nxt_ff.rdData = {cur_ff.result, RESULT_PAD_ZERO};
				nxt_ff.waitCyc = 1'b1;
			end else if (memAddr == ADDR_RESULT_HIGH) begin
				nxt_ff.rdData = {HIGH_BYTE_ZERO, cur_ff.result[9:2]};
				nxt_ff.waitCyc = 1'b1;
			end else if (memAddr == ADDR_MODE) begin
				nxt_ff.rdData = {HIGH_BYTE_ZERO, cur_ff.mode};
			end else if (memAddr == ADDR_CHANNEL) begin
				nxt_ff.rdData = {HIGH_BYTE_ZERO, BYTE_PAD_ZERO, cur_ff.chan};
			end else begin
				nxt_ff.rdData = {HIGH_BYTE_ZERO, HIGH_BYTE_ZERO};
			end
		end

		// the comparator itself draws power, so it follows both bits
		nxt_ff.compPower = nxt_ff.mode[MODE_ENABLE_BIT]
			|| nxt_ff.mode[MODE_COMP_BIT];

		if (core.sarDone) begin
			nxt_ff.result = core.sarCode;
			nxt_ff.irq = 1'b1;
		end

		case (cur_ff.st)
			CONV_IDLE: begin
				if (convEnable) begin
					nxt_ff.st = CONV_SAMPLE;
					nxt_ff.periods = 6'h00;
					nxt_ff.track = 1'b1;
				end
			end
			CONV_SAMPLE: begin
				if (core.tick) begin
					if (cur_ff.periods == sampleLast) begin
						nxt_ff.st = CONV_APPROX;
						nxt_ff.track = 1'b0;
					end else begin
						nxt_ff.periods = cur_ff.periods + PERIOD_STEP;
					end
				end
			end
			CONV_APPROX: begin
				if (core.sarDone) begin
					// back to back: the next sample starts at once
					nxt_ff.st = CONV_SAMPLE;
					nxt_ff.periods = 6'h00;
					nxt_ff.track = 1'b1;
				end
			end
			default: begin
				nxt_ff.st = CONV_IDLE;
			end
		endcase
		if (!convEnable) begin
			nxt_ff.st = CONV_IDLE;
			nxt_ff.track = 1'b0;
			nxt_ff.periods = 6'h00;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_ff.mode <= MODE_RESET;
			cur_ff.chan <= CHAN_RESET;
			cur_ff.result <= RESULT_RESET;
			cur_ff.rdData <= 16'h0000;
			cur_ff.waitCyc <= 1'b0;
			cur_ff.irq <= 1'b0;
			cur_ff.st <= CONV_IDLE;
			cur_ff.periods <= 6'h00;
			cur_ff.track <= 1'b0;
			cur_ff.compPower <= 1'b0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign core.divRatio = ratio;
	assign core.divRun = (cur_ff.st != CONV_IDLE) && convEnable;
	assign core.compHigh = compHigh;
	assign core.sarStart = core.tick && (cur_ff.st == CONV_SAMPLE)
		&& (cur_ff.periods == sampleLast) && convEnable;
	assign core.sarStep = core.tick && (cur_ff.st == CONV_APPROX) && convEnable;

	assign memRdData = cur_ff.rdData;
	assign memWait = cur_ff.waitCyc;
	assign trialCode = core.trialCode;
	assign trackInput = cur_ff.track;
	assign compPowerOn = cur_ff.compPower;
	assign channelSel = cur_ff.chan;
	assign conversion_done_irq = cur_ff.irq;

	a_mode_byte_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(memWrEn && memAddr == ADDR_MODE) |=> cur_ff.mode == $past(memWrData))
		else $error("mode byte write not stored");
	a_stop_halts_conv: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!cur_ff.mode[MODE_ENABLE_BIT] |-> (cur_ff.st == CONV_IDLE && !trackInput))
		else $error("conversion active with enable bit clear");
	a_comp_power_bits: assert property (@(posedge ref_clk) disable iff (!reset_n)
		compPowerOn == (cur_ff.mode[MODE_ENABLE_BIT] || cur_ff.mode[MODE_COMP_BIT]))
		else $error("comparator power does not follow mode bits");
	a_mode_write_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(memBitWrEn && memAddr == ADDR_MODE) |=> memWait ##1 !memWait)
		else $error("mode write without single wait cycle");
	// gated by divRun: a stop write retimes the divider in its own edge
	a_normal_div16: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(core.divRun && cur_ff.mode[MODE_TIME_MSB]
			&& cur_ff.mode[MODE_RANGE_MSB:MODE_RANGE_LSB] == RANGE_NORMAL)
		|-> core.divRatio == DIV_16)
		else $error("wrong divider for long normal conversion");
	a_result_low_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(memRdEn && memAddr == ADDR_RESULT_WORD) |=> memRdData[5:0] == RESULT_PAD_ZERO)
		else $error("result word low bits not zero");
	a_high_byte_map: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(memRdEn && memAddr == ADDR_RESULT_HIGH)
		|=> memRdData == {HIGH_BYTE_ZERO, $past(cur_ff.result[9:2])})
		else $error("high byte does not hold upper result bits");
	a_done_copies_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
		core.sarDone |=> (conversion_done_irq && cur_ff.result == $past(core.sarCode)))
		else $error("conversion end without result copy and request");
	a_hold_in_approx: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(cur_ff.st == CONV_APPROX) |-> !trackInput)
		else $error("input tracked during approximation");
	a_sample_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(core.divRun && cur_ff.st == CONV_SAMPLE) |-> cur_ff.periods <= sampleLast)
		else $error("sample period count overran");
	a_irq_single_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
		conversion_done_irq |=> !conversion_done_irq)
		else $error("conversion-done request longer than one cycle");
	a_result_word_map: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(memRdEn && memAddr == ADDR_RESULT_WORD)
		|=> memRdData == {$past(cur_ff.result), RESULT_PAD_ZERO})
		else $error("result word not left-justified");
	a_chan_write_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(memWrEn && memAddr == ADDR_CHANNEL) |=> channelSel == $past(memWrData[CHAN_WIDTH-1:0]))
		else $error("channel byte write not stored");
	a_busy_legal_chan: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(cur_ff.st != CONV_IDLE) |-> cur_ff.chan <= CHAN_LAST)
		else $error("conversion running on a prohibited channel");
	a_low_div12: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(core.divRun && cur_ff.mode[MODE_TIME_MSB:MODE_TIME_LSB] == TIME_CODE_0
			&& cur_ff.mode[MODE_RANGE_MSB:MODE_RANGE_LSB] == RANGE_LOW)
		|-> core.divRatio == DIV_12)
		else $error("wrong divider for slowest low-range conversion");
	a_start_hold_msb: assert property (@(posedge ref_clk) disable iff (!reset_n)
		core.sarStart |=> (!trackInput && trialCode == SAR_MSB_CODE))
		else $error("approximation start without hold or msb trial");
endmodule
`default_nettype wire

// >>> testbench/analog_front_model.sv
// behavioural input selector, sample-and-hold and comparator facing the converter
`timescale 1ns/100ps
`default_nettype none
module analog_front_model (
	input  wire logic            ref_clk,
	input  wire logic [5:0][9:0] chanLevel,
	input  wire logic [2:0]      channelSel,
	input  wire logic            trackInput,
	input  wire logic            compPowerOn,
	input  wire logic [9:0]      trialCode,
	output logic                 compHigh
);
	logic [9:0] heldLevel_ff = 10'h000;
	logic       noise_ff = 1'b0;

	always @(posedge ref_clk) begin
		noise_ff <= ~noise_ff;
		// prohibited channels select nothing, so the hold keeps its old value
		if (trackInput && channelSel <= 3'h5) begin
			heldLevel_ff <= chanLevel[channelSel];
		end
	end

	// unpowered comparator toggles, never a steady guess
	assign compHigh = compPowerOn ? (heldLevel_ff >= trialCode) : noise_ff;
endmodule
`default_nettype wire

// >>> testbench/tb_sar_adc_mode_and_result.sv
// self-checking bench for the converter mode and result block
`timescale 1ns/100ps
`default_nettype none
module tb_sar_adc_mode_and_result;
	import sar_adc_pkg::*;

	typedef struct packed {
		logic [7:0] mode;
		logic [2:0] chan;
		logic [9:0] period;
	} row_s;

	logic            ref_clk;
	logic            reset_n;
	logic [15:0]     memAddr;
	logic [7:0]      memWrData;
	logic            memWrEn;
	logic            memBitWrEn;
	logic [2:0]      memBitIdx;
	logic            memRdEn;
	logic            compHigh;
	logic [15:0]     memRdData;
	logic            memWait;
	logic [9:0]      trialCode;
	logic            trackInput;
	logic            compPowerOn;
	logic [2:0]      channelSel;
	logic            conversion_done_irq;
	logic [5:0][9:0] chanLevel;
	logic            hit;
	logic [15:0]     rdVal;
	row_s            rows [14];
	int              mismatches;
	int              checkCount;
	int              cycles = 0;
	int              n;

	sar_adc_mode_and_result uut (
		.ref_clk             (ref_clk),
		.reset_n             (reset_n),
		.memAddr             (memAddr),
		.memWrData           (memWrData),
		.memWrEn             (memWrEn),
		.memBitWrEn          (memBitWrEn),
		.memBitIdx           (memBitIdx),
		.memRdEn             (memRdEn),
		.compHigh            (compHigh),
		.memRdData           (memRdData),
		.memWait             (memWait),
		.trialCode           (trialCode),
		.trackInput          (trackInput),
		.compPowerOn         (compPowerOn),
		.channelSel          (channelSel),
		.conversion_done_irq (conversion_done_irq)
	);

	analog_front_model front (
		.ref_clk     (ref_clk),
		.chanLevel   (chanLevel),
		.channelSel  (channelSel),
		.trackInput  (trackInput),
		.compPowerOn (compPowerOn),
		.trialCode   (trialCode),
		.compHigh    (compHigh)
	);

	always #50 ref_clk = ~ref_clk;

	task automatic endOfTest;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// generous ceiling: the whole sequence needs roughly 10000 cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			mismatches++;
			endOfTest();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checkCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one access; a gap cycle first so strobes never drop and rise in one step
	task automatic busOp(input logic wr, input logic bitw, input logic [15:0] a,
			input logic [7:0] d, input logic [2:0] idx, input logic expWait);
		@(negedge ref_clk);
		memAddr = a;
		memWrData = d;
		memBitIdx = idx;
		memWrEn = wr & ~bitw;
		memBitWrEn = bitw;
		memRdEn = ~wr;
		@(negedge ref_clk);
		memWrEn = 1'b0;
		memBitWrEn = 1'b0;
		memRdEn = 1'b0;
		rdVal = memRdData;
		check({15'h0000, memWait}, {15'h0000, expWait});
	endtask

	task automatic wrReg(input logic [15:0] a, input logic [7:0] d, input logic ew);
		busOp(1'b1, 1'b0, a, d, 3'h0, ew);
	endtask

	task automatic bitWr(input logic [2:0] idx, input logic v);
		busOp(1'b1, 1'b1, ADDR_MODE, {7'h00, v}, idx, 1'b1);
	endtask

	task automatic rdReg(input logic [15:0] a, input logic ew, input logic [15:0] exp);
		busOp(1'b0, 1'b0, a, 8'h00, 3'h0, ew);
		check(rdVal, exp);
	endtask

	// n ends as the cycle count up to the pulse
	task automatic waitIrq(input int lim, output logic got);
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			@(negedge ref_clk);
			if (conversion_done_irq === 1'b1) begin
				got = 1'b1;
				n = i + 1;
			end
		end
	endtask

	task automatic expectFlag(input logic seen, input logic exp);
		check({15'h0000, seen}, {15'h0000, exp});
	endtask

	initial begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		memAddr = 16'h0000;
		memWrData = 8'h00;
		memWrEn = 1'b0;
		memBitWrEn = 1'b0;
		memBitIdx = 3'h0;
		memRdEn = 1'b0;
		mismatches = 0;
		checkCount = 0;
		n = 0;
		chanLevel = {10'h1fe, 10'h201, 10'h2aa, 10'h155, 10'h000, 10'h3ff};
		// mode byte, channel, cycles between completions
		rows = '{{8'hc1, 3'h0, 10'h160}, {8'hf9, 3'h1, 10'h160}, {8'h81, 3'h2, 10'h108},
			{8'h89, 3'h3, 10'h0b0}, {8'h91, 3'h4, 10'h084}, {8'h99, 3'h5, 10'h058},
			{8'ha1, 3'h0, 10'h042}, {8'ha9, 3'h1, 10'h02c}, {8'h83, 3'h2, 10'h1e0},
			{8'h8b, 3'h3, 10'h140}, {8'h93, 3'h4, 10'h0f0}, {8'h9b, 3'h5, 10'h0a0},
			{8'ha3, 3'h0, 10'h078}, {8'hab, 3'h1, 10'h050}};
		repeat (5) @(negedge ref_clk);
		reset_n = 1'b1;
		for (int k = 0; k < 14; k++) begin
			// stop before retiming, as software must
			wrReg(ADDR_MODE, MODE_RESET, 1'b1);
			wrReg(ADDR_CHANNEL, {5'h00, rows[k].chan}, 1'b1);
			wrReg(ADDR_MODE, rows[k].mode, 1'b1);
			check({13'h0000, channelSel}, {13'h0000, rows[k].chan});
			expectFlag(compPowerOn, 1'b1);
			expectFlag(trackInput, 1'b1);
			// first result thrown away: comparator gets no settling time here
			waitIrq(1200, hit);
			waitIrq(1200, hit);
			expectFlag(hit, 1'b1);
			check({6'h00, n[9:0]}, {6'h00, rows[k].period});
			rdReg(ADDR_RESULT_WORD, 1'b1, {chanLevel[rows[k].chan], RESULT_PAD_ZERO});
			rdReg(ADDR_RESULT_HIGH, 1'b1, {HIGH_BYTE_ZERO, chanLevel[rows[k].chan][9:2]});
			$display("row %0d done", k);
		end
		wrReg(ADDR_MODE, 8'h00, 1'b1);
		wrReg(ADDR_MODE, 8'hb1, 1'b1);
		waitIrq(800, hit);
		expectFlag(hit, 1'b0);
		wrReg(ADDR_MODE, 8'h00, 1'b1);
		wrReg(ADDR_MODE, 8'hc3, 1'b1);
		waitIrq(1000, hit);
		expectFlag(hit, 1'b0);
		wrReg(ADDR_MODE, 8'h00, 1'b1);
		wrReg(ADDR_CHANNEL, 8'hfe, 1'b1);
		check({13'h0000, channelSel}, 16'h0006);
		wrReg(ADDR_MODE, 8'ha9, 1'b1);
		waitIrq(200, hit);
		expectFlag(hit, 1'b0);
		$display("prohibited settings done");
		wrReg(ADDR_MODE, 8'h00, 1'b1);
		wrReg(ADDR_CHANNEL, 8'hfd, 1'b1);
		wrReg(ADDR_MODE, 8'h01, 1'b1);
		expectFlag(compPowerOn, 1'b1);
		expectFlag(trackInput, 1'b0);
		waitIrq(400, hit);
		expectFlag(hit, 1'b0);
		rdReg(ADDR_MODE, 1'b0, 16'h0001);
		wrReg(ADDR_MODE, 8'h00, 1'b1);
		expectFlag(compPowerOn, 1'b0);
		// comparator bit clear, enable set: still converts with comparator powered
		wrReg(ADDR_MODE, 8'ha8, 1'b1);
		expectFlag(compPowerOn, 1'b1);
		waitIrq(200, hit);
		expectFlag(hit, 1'b1);
		$display("power modes done");
		wrReg(ADDR_MODE, 8'h00, 1'b1);
		bitWr(3'h0, 1'b1);
		rdReg(ADDR_MODE, 1'b0, 16'h0001);
		bitWr(3'h5, 1'b1);
		bitWr(3'h7, 1'b1);
		waitIrq(200, hit);
		expectFlag(hit, 1'b1);
		rdReg(ADDR_MODE, 1'b0, 16'h00a1);
		bitWr(3'h7, 1'b0);
		waitIrq(200, hit);
		expectFlag(hit, 1'b0);
		$display("bit writes done");
		wrReg(ADDR_CHANNEL, 8'h00, 1'b1);
		wrReg(ADDR_MODE, 8'hc1, 1'b1);
		waitIrq(1200, hit);
		repeat (100) @(negedge ref_clk);
		wrReg(ADDR_MODE, 8'h01, 1'b1);
		expectFlag(trackInput, 1'b0);
		waitIrq(800, hit);
		expectFlag(hit, 1'b0);
		rdReg(ADDR_RESULT_WORD, 1'b1, {10'h3ff, 6'h00});
		rdReg(16'h1234, 1'b0, 16'h0000);
		wrReg(ADDR_RESULT_WORD, 8'h55, 1'b0);
		wrReg(ADDR_RESULT_HIGH, 8'haa, 1'b0);
		rdReg(ADDR_RESULT_WORD, 1'b1, {10'h3ff, 6'h00});
		$display("abort and read-only done");
		wrReg(ADDR_MODE, 8'h81, 1'b1);
		repeat (50) @(negedge ref_clk);
		reset_n = 1'b0;
		repeat (5) @(negedge ref_clk);
		reset_n = 1'b1;
		expectFlag(compPowerOn, 1'b0);
		check({13'h0000, channelSel}, 16'h0000);
		check({6'h00, trialCode}, 16'h0000);
		expectFlag(trackInput, 1'b0);
		expectFlag(conversion_done_irq, 1'b0);
		rdReg(ADDR_RESULT_WORD, 1'b1, 16'h0000);
		rdReg(ADDR_RESULT_HIGH, 1'b1, 16'h0000);
		rdReg(ADDR_MODE, 1'b0, 16'h0000);
		$display("second reset done");
		endOfTest();
	end
endmodule
`default_nettype wire
